//--- verilog/exc_pkg.sv
// Shared constants, types and encodings for the exception sequencer
// Behaviour
// [RQ1] Simultaneous exceptions: accept only the highest ranked
// [RQ2] Decode-detected exceptions share one priority class
// [RQ3] Older instruction's exception wins over younger's
// [RQ4] Hold-off clear: exceptions and interrupts accepted normally
// [RQ5] Hold-off set, non-break exception: manual reset path
// [RQ6] Ordinary interrupt waits until hold-off is cleared
// [RQ7] Blocked nonmaskable interrupt: held or taken, per setting
// [RQ8] Return restores program counter and status, then branches
// [RQ9] Handler sets hold-off before reloading saved state
// [RQ10] Power-on: code 000, full init, reset vector
// [RQ11] Manual reset: code 020, manual init, reset vector
// [RQ12] Debug opcode 0110/0111: code 000, reset vector
// [RQ13] Instruction multi-hit: record address, code 140, reset
// [RQ14] Data multi-hit: record address, code 140, reset
// [RQ15] Translation faults load fault address and page number
// [RQ16] General entry saves pc, status and stack register
// [RQ17] General entry sets hold-off, privilege and bank bits
// [RQ18] Data miss: code 040 read, 060 write, offset 400
// [RQ19] Instruction miss: code 040, offset 400
// [RQ20] Initial page write: code 080, offset 100
// [RQ21] Codes go into bits 11:0 of event registers
// [RQ22] Handler address is vector base plus offset
// [RQ23] Rank by level, then order; lower wins
// [RQ24] Blocked user break goes to break controller
package exc_pkg;

	// ---------------------------------------------------------------
	// Vectors and offsets
	// ---------------------------------------------------------------
	localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
	localparam logic [31:0] OFF_GENERAL  = 32'h0000_0100;
	localparam logic [31:0] OFF_MISS     = 32'h0000_0400;
	localparam logic [31:0] OFF_INTR     = 32'h0000_0600;

	// ---------------------------------------------------------------
	// Event codes, bits 11:0 of the event registers
	// ---------------------------------------------------------------
	localparam logic [11:0] CODE_POWER   = 12'h000;
	localparam logic [11:0] CODE_MANUAL  = 12'h020;
	localparam logic [11:0] CODE_MULTI   = 12'h140;
	localparam logic [11:0] CODE_MISS_RD = 12'h040;
	localparam logic [11:0] CODE_MISS_WR = 12'h060;
	localparam logic [11:0] CODE_IPWRITE = 12'h080;
	localparam logic [11:0] CODE_UBREAK  = 12'h1E0;
	localparam logic [11:0] CODE_NMI     = 12'h1C0;

	// ---------------------------------------------------------------
	// Debug opcode field and status word layout
	// ---------------------------------------------------------------
	localparam logic [3:0]  DBG_RST_NEGATE = 4'h6;
	localparam logic [3:0]  DBG_RST_ASSERT = 4'h7;
	localparam int          PRIV_BIT       = 30;
	localparam int          BANK_BIT       = 29;
	localparam int          HOLD_BIT       = 28;
	localparam int          PAGE_NUM_LSB   = 10;
	localparam logic [31:0] STATUS_RESET   = 32'h7000_00F0;
	localparam logic [31:0] VECBASE_RESET  = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	// Reset-class requests, one cycle each
	typedef struct packed {
		logic powerOn;
		logic manual;
		logic debugReset;
		logic itlbMulti;
		logic utlbMulti;
	} resetReq_t;

	// General exceptions raised for one instruction
	typedef struct packed {
		logic        uBreak;
		logic        itlbMiss;
		logic        decodeExc;
		logic [11:0] decodeCode;
		logic        utlbMiss;
		logic        isWrite;
		logic        initPageWrite;
		logic [31:0] pc;
		logic [31:0] faultAddr;
	} slotReq_t;

	// Architectural state kept by the sequencer
	typedef struct packed {
		logic [31:0] statusWord;
		logic [31:0] savedPc;
		logic [31:0] savedStatus;
		logic [31:0] savedStackPtr;
		logic [11:0] exceptionEventCode;
		logic [11:0] interruptEventCode;
		logic [31:0] faultAddressReg;
		logic [31:0] pageTableEntryHigh;
		logic [31:0] vectorBase;
	} archState_t;

	localparam archState_t ARCH_RESET = '{
		statusWord: STATUS_RESET, savedPc: '0, savedStatus: '0, savedStackPtr: '0,
		exceptionEventCode: CODE_POWER, interruptEventCode: '0,
		faultAddressReg: '0, pageTableEntryHigh: '0, vectorBase: VECBASE_RESET};

	// Accepted event kind
	typedef enum logic [3:0] {
		K_NONE, K_POWER, K_DEBUG, K_MANUAL, K_IMULTI, K_DMULTI,
		K_UBREAK, K_IMISS, K_DECODE, K_DMISS, K_IPWRITE, K_NMI, K_IRQ
	} excKind_t;

	// Sequencer phase
	typedef enum logic {PH_BOOT, PH_RUN} phase_t;

endpackage

//--- verilog/exc_priority_select.sv
// Priority selection among simultaneous reset-class and general exceptions
`timescale 1ns/1ps
module exc_priority_select (
	// Requests
	input  exc_pkg::resetReq_t resets,
	input  exc_pkg::slotReq_t  olderSlot,
	input  exc_pkg::slotReq_t  youngerSlot,
	// Choice
	output exc_pkg::excKind_t  kind,
	output logic               fromYounger
);

	// ---------------------------------------------------------------
	// Pick within one instruction by priority order
	// ---------------------------------------------------------------
	function automatic exc_pkg::excKind_t slotPick(input exc_pkg::slotReq_t s);
		if (s.uBreak)             slotPick = exc_pkg::K_UBREAK;  // Order 0 [RQ23]
		else if (s.itlbMiss)      slotPick = exc_pkg::K_IMISS;   // Order 2
		else if (s.decodeExc)     slotPick = exc_pkg::K_DECODE;  // One class, order 4 [RQ2]
		else if (s.utlbMiss)      slotPick = exc_pkg::K_DMISS;   // Order 6
		else if (s.initPageWrite) slotPick = exc_pkg::K_IPWRITE; // Order 9
		else                      slotPick = exc_pkg::K_NONE;
	endfunction

	exc_pkg::excKind_t olderKind;   // Best of the older instruction
	exc_pkg::excKind_t youngerKind; // Best of the younger instruction

	// ---------------------------------------------------------------
	// Level 1 resets first, then general exceptions in program order
	// ---------------------------------------------------------------
	always_comb begin
		olderKind   = slotPick(olderSlot);
		youngerKind = slotPick(youngerSlot);
		fromYounger = 1'b0;
		if (resets.powerOn)         kind = exc_pkg::K_POWER;   // [RQ1]
		else if (resets.debugReset) kind = exc_pkg::K_DEBUG;
		else if (resets.manual)     kind = exc_pkg::K_MANUAL;
		else if (resets.itlbMulti)  kind = exc_pkg::K_IMULTI;
		else if (resets.utlbMulti)  kind = exc_pkg::K_DMULTI;
		else if (olderKind != exc_pkg::K_NONE) begin
			kind = olderKind;                                  // [RQ3]
		end else begin
			kind        = youngerKind;
			fromYounger = (youngerKind != exc_pkg::K_NONE);
		end
	end

endmodule

//--- verilog/exc_vector_form.sv
// Event code and handler address for an accepted event
`timescale 1ns/1ps
module exc_vector_form (
	// Event
	input  exc_pkg::excKind_t kind,
	input  logic              isWrite,
	input  logic [11:0]       decodeCode,
	input  logic [11:0]       irqCode,
	input  logic [31:0]       vectorBase,
	// Result
	output logic [11:0]       code,
	output logic [31:0]       target
);

	// ---------------------------------------------------------------
	// Code table and base plus offset
	// ---------------------------------------------------------------
	always_comb begin
		code   = exc_pkg::CODE_MANUAL;
		target = exc_pkg::RESET_VECTOR;
		unique case (kind)
			exc_pkg::K_POWER, exc_pkg::K_DEBUG: code = exc_pkg::CODE_POWER;  // [RQ10] [RQ12]
			exc_pkg::K_IMULTI, exc_pkg::K_DMULTI: code = exc_pkg::CODE_MULTI; // [RQ13] [RQ14]
			exc_pkg::K_UBREAK: begin
				code   = exc_pkg::CODE_UBREAK;
				target = vectorBase + exc_pkg::OFF_GENERAL;
			end
			exc_pkg::K_IMISS: begin
				code   = exc_pkg::CODE_MISS_RD;                       // [RQ19]
				target = vectorBase + exc_pkg::OFF_MISS;              // [RQ22]
			end
			exc_pkg::K_DECODE: begin
				code   = decodeCode;
				target = vectorBase + exc_pkg::OFF_GENERAL;
			end
			exc_pkg::K_DMISS: begin
				code   = isWrite ? exc_pkg::CODE_MISS_WR : exc_pkg::CODE_MISS_RD; // [RQ18]
				target = vectorBase + exc_pkg::OFF_MISS;
			end
			exc_pkg::K_IPWRITE: begin
				code   = exc_pkg::CODE_IPWRITE;                       // [RQ20]
				target = vectorBase + exc_pkg::OFF_GENERAL;
			end
			exc_pkg::K_NMI: begin
				code   = exc_pkg::CODE_NMI;
				target = vectorBase + exc_pkg::OFF_INTR;
			end
			exc_pkg::K_IRQ: begin
				code   = irqCode;
				target = vectorBase + exc_pkg::OFF_INTR;
			end
			default: ;                                                // Manual and none: reset vector
		endcase
	end

endmodule

//--- verilog/cpu_exception_sequencer.sv
// Exception acceptance, entry sequencing and return for the core
`timescale 1ns/1ps
module cpu_exception_sequencer (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                nrst,
	// Reset-class sources
	input  wire logic                powerOnReq,
	input  wire logic                manualReq,
	input  wire logic                debugOpcodeWr,
	input  wire logic [7:0]          debugOpcodeField,
	input  wire logic                itlbMultiHit,
	input  wire logic                utlbMultiHit,
	input  wire logic [31:0]         multiHitAddr,
	// General exceptions, older and younger instruction
	input  wire exc_pkg::slotReq_t   olderSlot,
	input  wire exc_pkg::slotReq_t   youngerSlot,
	input  wire logic [31:0]         stackRegister,
	// Interrupts
	input  wire logic                nmiReq,
	input  wire logic                nmiAcceptBlocked,
	input  wire logic                irqReq,
	input  wire logic [11:0]         irqCode,
	// Software side
	input  wire logic                returnReq,
	input  wire logic                statusWr,
	input  wire logic [31:0]         statusWrData,
	input  wire logic                vectorBaseWr,
	input  wire logic [31:0]         vectorBaseWrData,
	// Control flow and init
	output logic                     branchValid,
	output logic [31:0]              branchTarget,
	output logic                     powerInit,
	output logic                     manualInit,
	output logic                     breakToController,
	output logic                     irqAck,
	// Architectural state
	output exc_pkg::archState_t      archState
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	exc_pkg::archState_t st_q, st_d;       // Registers seen by software
	exc_pkg::phase_t     phase_q, phase_d; // Boot branch pending after reset
	logic                nmiPend_q, nmiPend_d;
	logic                branchValid_q, branchValid_d;
	logic [31:0]         branchTarget_q, branchTarget_d;
	logic                powerInit_q, powerInit_d;
	logic                manualInit_q, manualInit_d;
	logic                break_q, break_d;
	logic                irqAck_q, irqAck_d;
	exc_pkg::resetReq_t  resets;           // Reset-class request bundle
	exc_pkg::excKind_t   excKind;          // Winner among exceptions
	exc_pkg::excKind_t   evKind;           // Event actually taken
	logic                fromYounger;      // Winner belongs to younger slot
	exc_pkg::slotReq_t   sel;              // Slot of the winner
	logic [11:0]         evCode;
	logic [31:0]         evTarget;
	logic                holdOff;          // Hold-off flag of the status word
	logic                resetPath;        // Goes to the reset vector
	logic                generalTake;      // General or interrupt entry
	logic                intrTake;
	logic                returnTake;
	logic [3:0]          dbgHi;

	assign holdOff = st_q.statusWord[exc_pkg::HOLD_BIT];
	assign dbgHi   = debugOpcodeField[7:4];
	assign sel     = fromYounger ? youngerSlot : olderSlot;

	// ---------------------------------------------------------------
	// Request bundle and priority
	// ---------------------------------------------------------------
	always_comb begin
		resets.powerOn    = powerOnReq;
		resets.manual     = manualReq;
		resets.debugReset = debugOpcodeWr &&
			(dbgHi == exc_pkg::DBG_RST_NEGATE || dbgHi == exc_pkg::DBG_RST_ASSERT); // [RQ12]
		resets.itlbMulti  = itlbMultiHit;
		resets.utlbMulti  = utlbMultiHit;
	end

	exc_priority_select u_select (
		.resets      (resets),
		.olderSlot   (olderSlot),
		.youngerSlot (youngerSlot),
		.kind        (excKind),
		.fromYounger (fromYounger)
	);

	// ---------------------------------------------------------------
	// Interrupts rank below every exception
	// ---------------------------------------------------------------
	always_comb begin
		intrTake = 1'b0;
		evKind   = excKind;
		if (phase_q == exc_pkg::PH_RUN && excKind == exc_pkg::K_NONE) begin
			if (nmiPend_q && (!holdOff || nmiAcceptBlocked)) begin  // [RQ7]
				evKind   = exc_pkg::K_NMI;
				intrTake = 1'b1;
			end else if (irqReq && !holdOff) begin                   // [RQ6] [RQ4]
				evKind   = exc_pkg::K_IRQ;
				intrTake = 1'b1;
			end
		end
	end

	exc_vector_form u_vector (
		.kind       (evKind),
		.isWrite    (sel.isWrite),
		.decodeCode (sel.decodeCode),
		.irqCode    (irqCode),
		.vectorBase (st_q.vectorBase),
		.code       (evCode),
		.target     (evTarget)
	);

	// ---------------------------------------------------------------
	// Next-state logic for all sequencer state
	// ---------------------------------------------------------------
	always_comb begin
		st_d           = st_q;
		phase_d        = exc_pkg::PH_RUN;
		nmiPend_d      = nmiPend_q;
		branchValid_d  = 1'b0;
		branchTarget_d = branchTarget_q;
		powerInit_d    = 1'b0;
		manualInit_d   = 1'b0;
		break_d        = 1'b0;
		irqAck_d       = 1'b0;
		resetPath      = 1'b0;
		generalTake    = 1'b0;
		returnTake     = 1'b0;
		if (phase_q == exc_pkg::PH_BOOT) begin
			// First fetch after power-on; state already holds init values
			branchValid_d  = 1'b1;                                    // [RQ10]
			branchTarget_d = exc_pkg::RESET_VECTOR;
			powerInit_d    = 1'b1;
		end else if (excKind inside {exc_pkg::K_POWER, exc_pkg::K_DEBUG, exc_pkg::K_MANUAL,
				exc_pkg::K_IMULTI, exc_pkg::K_DMULTI} ||
				(holdOff && excKind != exc_pkg::K_NONE && excKind != exc_pkg::K_UBREAK)) begin
			resetPath      = 1'b1;
			branchValid_d  = 1'b1;
			branchTarget_d = exc_pkg::RESET_VECTOR;
			if (excKind == exc_pkg::K_POWER) begin
				st_d        = exc_pkg::ARCH_RESET;                    // [RQ10]
				powerInit_d = 1'b1;
			end else begin
				st_d.statusWord = exc_pkg::STATUS_RESET;              // [RQ12] [RQ11]
				st_d.vectorBase = exc_pkg::VECBASE_RESET;
				manualInit_d    = (excKind != exc_pkg::K_DEBUG);
				// Blocked exceptions report as a manual reset
				st_d.exceptionEventCode = (holdOff && !(excKind inside {exc_pkg::K_DEBUG,
					exc_pkg::K_IMULTI, exc_pkg::K_DMULTI})) ? exc_pkg::CODE_MANUAL : evCode; // [RQ5] [RQ21]
				if (excKind == exc_pkg::K_IMULTI || excKind == exc_pkg::K_DMULTI) begin
					st_d.faultAddressReg = multiHitAddr;              // [RQ13] [RQ14]
					st_d.pageTableEntryHigh[31:exc_pkg::PAGE_NUM_LSB] = multiHitAddr[31:exc_pkg::PAGE_NUM_LSB];
				end
			end
			nmiPend_d = 1'b0;
		end else if (excKind == exc_pkg::K_UBREAK && holdOff) begin
			break_d = 1'b1;                                           // [RQ24]
		end else if (excKind != exc_pkg::K_NONE || intrTake) begin
			generalTake    = 1'b1;
			branchValid_d  = 1'b1;
			branchTarget_d = evTarget;                                // [RQ22]
			st_d.savedPc       = intrTake ? olderSlot.pc : sel.pc;    // [RQ16]
			st_d.savedStatus   = st_q.statusWord;
			st_d.savedStackPtr = stackRegister;
			st_d.statusWord[exc_pkg::HOLD_BIT] = 1'b1;                // [RQ17]
			st_d.statusWord[exc_pkg::PRIV_BIT] = 1'b1;
			st_d.statusWord[exc_pkg::BANK_BIT] = 1'b1;
			if (intrTake) begin
				st_d.interruptEventCode = evCode;                     // [RQ21]
				irqAck_d  = (evKind == exc_pkg::K_IRQ);
				nmiPend_d = (evKind == exc_pkg::K_NMI) ? 1'b0 : nmiPend_q;
			end else begin
				st_d.exceptionEventCode = evCode;
			end
			if (excKind inside {exc_pkg::K_IMISS, exc_pkg::K_DMISS, exc_pkg::K_IPWRITE}) begin
				// Page number only; address space id is left as it was
				st_d.faultAddressReg = sel.faultAddr;                 // [RQ15]
				st_d.pageTableEntryHigh[31:exc_pkg::PAGE_NUM_LSB] = sel.faultAddr[31:exc_pkg::PAGE_NUM_LSB];
			end
		end else if (returnReq) begin
			returnTake      = 1'b1;
			branchValid_d   = 1'b1;
			branchTarget_d  = st_q.savedPc;                           // [RQ8]
			st_d.statusWord = st_q.savedStatus;
		end else begin
			// Software writes lose to any event in the same cycle
			if (statusWr)     st_d.statusWord = statusWrData;
			if (vectorBaseWr) st_d.vectorBase = vectorBaseWrData;
		end
		// A new request wins over the clear of the pending flag
		if (nmiReq) nmiPend_d = 1'b1;
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q           <= exc_pkg::ARCH_RESET;
			phase_q        <= exc_pkg::PH_BOOT;
			nmiPend_q      <= 1'b0;
			branchValid_q  <= 1'b0;
			branchTarget_q <= exc_pkg::RESET_VECTOR;
			powerInit_q    <= 1'b0;
			manualInit_q   <= 1'b0;
			break_q        <= 1'b0;
			irqAck_q       <= 1'b0;
		end else begin
			st_q           <= st_d;
			phase_q        <= phase_d;
			nmiPend_q      <= nmiPend_d;
			branchValid_q  <= branchValid_d;
			branchTarget_q <= branchTarget_d;
			powerInit_q    <= powerInit_d;
			manualInit_q   <= manualInit_d;
			break_q        <= break_d;
			irqAck_q       <= irqAck_d;
		end
	end

	assign branchValid       = branchValid_q;
	assign branchTarget      = branchTarget_q;
	assign powerInit         = powerInit_q;
	assign manualInit        = manualInit_q;
	assign breakToController = break_q;
	assign irqAck            = irqAck_q;
	assign archState         = st_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_powerOn;
		phase_q == exc_pkg::PH_RUN && powerOnReq |=> branchValid_q && powerInit_q &&
			branchTarget_q == 32'hA000_0000 && st_q.exceptionEventCode == 12'h000;
	endproperty
	a_powerOn: assert property (p_powerOn) else $error("power-on entry wrong"); // [RQ10]

	property p_manual;
		phase_q == exc_pkg::PH_RUN && excKind == exc_pkg::K_MANUAL |=> manualInit_q &&
			st_q.exceptionEventCode == 12'h020 && branchTarget_q == 32'hA000_0000;
	endproperty
	a_manual: assert property (p_manual) else $error("manual reset entry wrong"); // [RQ11]

	property p_debug;
		phase_q == exc_pkg::PH_RUN && debugOpcodeWr && debugOpcodeField[7:5] == 3'h3 && !powerOnReq
			|=> st_q.exceptionEventCode == 12'h000 && st_q.vectorBase == 32'h0 && !manualInit_q;
	endproperty
	a_debug: assert property (p_debug) else $error("debug reset entry wrong"); // [RQ12]

	property p_multi;
		phase_q == exc_pkg::PH_RUN && (excKind == exc_pkg::K_IMULTI || excKind == exc_pkg::K_DMULTI)
			|=> st_q.exceptionEventCode == 12'h140 && st_q.faultAddressReg == $past(multiHitAddr);
	endproperty
	a_multi: assert property (p_multi) else $error("multi-hit entry wrong"); // [RQ13] [RQ14]

	property p_blocked;
		phase_q == exc_pkg::PH_RUN && holdOff && excKind inside {exc_pkg::K_IMISS, exc_pkg::K_DMISS,
			exc_pkg::K_DECODE, exc_pkg::K_IPWRITE} |=> branchValid_q && branchTarget_q == 32'hA000_0000 &&
			st_q.exceptionEventCode == 12'h020 && manualInit_q;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked exception not reset"); // [RQ5]

	property p_entry;
		phase_q == exc_pkg::PH_RUN && !holdOff && excKind == exc_pkg::K_DMISS |=>
			st_q.statusWord[30:28] == 3'h7 && st_q.savedPc == $past(sel.pc) &&
			st_q.savedStatus == $past(st_q.statusWord) && branchTarget_q == $past(st_q.vectorBase) + 32'h400 &&
			st_q.pageTableEntryHigh[9:0] == $past(st_q.pageTableEntryHigh[9:0]);
	endproperty
	a_entry: assert property (p_entry) else $error("data miss entry wrong"); // [RQ16] [RQ17] [RQ18] [RQ15]

	property p_irqHeld;
		phase_q == exc_pkg::PH_RUN && irqReq && holdOff && excKind == exc_pkg::K_NONE
			&& !nmiPend_q |=> !irqAck_q;
	endproperty
	a_irqHeld: assert property (p_irqHeld) else $error("interrupt taken under hold-off"); // [RQ6]

	property p_return;
		returnTake |=> branchValid_q && branchTarget_q == $past(st_q.savedPc) &&
			st_q.statusWord == $past(st_q.savedStatus);
	endproperty
	a_return: assert property (p_return) else $error("return did not restore"); // [RQ8]

	property p_order;
		olderSlot.initPageWrite && youngerSlot.uBreak && excKind != exc_pkg::K_NONE |-> !fromYounger;
	endproperty
	a_order: assert property (p_order) else $error("younger exception won"); // [RQ3]

	property p_break;
		phase_q == exc_pkg::PH_RUN && holdOff && excKind == exc_pkg::K_UBREAK |=>
			breakToController && !branchValid_q;
	endproperty
	a_break: assert property (p_break) else $error("blocked break not passed on"); // [RQ24]

	c_powerOn: cover property (powerInit_q);
	c_miss:    cover property (generalTake && excKind == exc_pkg::K_IMISS);
	c_nmiHeld: cover property (nmiPend_q && holdOff ##1 intrTake);
	c_return:  cover property (generalTake ##[1:20] returnTake);

endmodule

//--- tb/pipe_model.sv
// Behavioural pipeline and translation side that feeds the sequencer
`timescale 1ns/1ps
module pipe_model (
	// Core side
	input  wire logic         clock,
	input  wire logic         irqAck,
	// Requests
	output exc_pkg::slotReq_t olderSlot,
	output exc_pkg::slotReq_t youngerSlot,
	output logic              irqReq
);
	initial begin
		olderSlot = '0;
		youngerSlot = '0;
		irqReq = 1'h0;
	end
	// One-cycle request pair, older first in program order
	task automatic issue(input exc_pkg::slotReq_t o, input exc_pkg::slotReq_t y);
		olderSlot = o;
		youngerSlot = y;
		@(posedge clock);
		#1;
		olderSlot = '0;
		youngerSlot = '0;
	endtask
	// Source keeps asking until the core acknowledges
	always @(posedge clock) begin
		if (irqAck === 1'h1)
			irqReq <= #1 1'h0;
	end
endmodule

//--- tb/tb_cpu_exception_sequencer.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
module tb_cpu_exception_sequencer;
	localparam logic [31:0] VB = 32'h9C08_0000;
	localparam logic [31:0] RV = exc_pkg::RESET_VECTOR;
	logic                clock = 1'h0;
	logic                nrst = 1'h0;
	logic                powerOnReq = 1'h0, manualReq = 1'h0, debugOpcodeWr = 1'h0;
	logic                itlbMultiHit = 1'h0, utlbMultiHit = 1'h0, nmiReq = 1'h0;
	logic                nmiAcceptBlocked = 1'h0, returnReq = 1'h0, statusWr = 1'h0, vectorBaseWr = 1'h0;
	logic [7:0]          debugOpcodeField = '0;
	logic [11:0]         irqCode = 12'h3C0;
	logic [31:0]         multiHitAddr = '0, stackRegister = 32'h0000_8F00;
	logic [31:0]         statusWrData = '0, vectorBaseWrData = '0, branchTarget;
	logic                branchValid, powerInit, manualInit, breakToController, irqAck, irqReq;
	exc_pkg::archState_t archState;
	exc_pkg::slotReq_t   olderSlot, youngerSlot, s, y;
	int                  n_fail = 0, n_tests = 0;

	pipe_model pm (.clock, .irqAck, .olderSlot, .youngerSlot, .irqReq);
	cpu_exception_sequencer dut_u (.clock, .nrst, .powerOnReq, .manualReq, .debugOpcodeWr,
		.debugOpcodeField, .itlbMultiHit, .utlbMultiHit, .multiHitAddr, .olderSlot, .youngerSlot,
		.stackRegister, .nmiReq, .nmiAcceptBlocked, .irqReq, .irqCode, .returnReq, .statusWr,
		.statusWrData, .vectorBaseWr, .vectorBaseWrData, .branchValid, .branchTarget, .powerInit,
		.manualInit, .breakToController, .irqAck, .archState);

	initial begin
		forever #2.5 clock = ~clock;
	end
	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	// Strobe held across exactly one sampling edge
	task automatic pulse(ref logic sig);
		sig = 1'h1;
		tick;
		sig = 1'h0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic entry(input logic [11:0] c, input logic [31:0] t);
		chk(branchValid, 1'h1);
		chk(branchTarget, t);
		chk(archState.exceptionEventCode, c);
	endtask
	task automatic t_miss;
		s = '0;
		s.utlbMiss = 1'h1;
		s.pc = 32'h0000_1000;
		s.faultAddr = 32'h1234_5678;
		pm.issue(s, '0);
		entry(12'h040, VB + exc_pkg::OFF_MISS);
		chk(archState.savedPc, s.pc);
		chk(archState.savedStackPtr, stackRegister);
		chk(archState.statusWord[30:28], 3'h7);
		chk(archState.faultAddressReg, s.faultAddr);
		chk(archState.pageTableEntryHigh, {s.faultAddr[31:10], 10'h000});
		// Handler keeps hold-off set while it reloads spilled state
		statusWrData = 32'h7000_0000;
		pulse(statusWr);
		pulse(returnReq);
		chk(branchTarget, s.pc);
		chk(archState.statusWord, '0);
	endtask
	// Code kinds, program order and in-slot rank, each left again by a return
	task automatic t_codes;
		logic [11:0] c [6] = '{12'h060, 12'h080, 12'h040, 12'h080, 12'h040, 12'h180};
		logic [31:0] o [6] = '{32'h400, 32'h100, 32'h400, 32'h100, 32'h400, 32'h100};
		for (int i = 0; i < 6; i++) begin
			s = '0;
			y = '0;
			s.pc = 32'h0000_2000 + i;
			s.decodeCode = 12'h180;
			s.utlbMiss = (i == 0);
			s.isWrite = (i == 0);
			s.initPageWrite = (i == 1 || i == 3 || i == 4);
			s.itlbMiss = (i == 2 || i == 4);
			s.decodeExc = (i == 5);
			y.itlbMiss = (i == 3);
			pm.issue(s, y);
			entry(c[i], VB + o[i]);
			chk(archState.savedPc, s.pc);
			pulse(returnReq);
		end
	endtask
	task automatic t_block;
		statusWrData = 32'h1000_0000;
		pulse(statusWr);
		pm.irqReq = 1'h1;
		s = '0;
		s.uBreak = 1'h1;
		pm.issue(s, '0);
		chk(breakToController, 1'h1);
		chk(irqAck, 1'h0);
		s.uBreak = 1'h0;
		s.utlbMiss = 1'h1;
		pm.issue(s, '0);
		entry(12'h020, RV);
		chk(manualInit, 1'h1);
		statusWrData = '0;
		pulse(statusWr);
		tick;
		chk(irqAck, 1'h1);
		chk(archState.interruptEventCode, irqCode);
		chk(branchTarget, exc_pkg::OFF_INTR);
	endtask
	task automatic t_resets;
		pulse(manualReq);
		entry(12'h020, RV);
		chk(manualInit, 1'h1);
		debugOpcodeField = 8'h65;
		pulse(debugOpcodeWr);
		entry(12'h000, RV);
		multiHitAddr = 32'hCAFE_0400;
		pulse(itlbMultiHit);
		entry(12'h140, RV);
		chk(archState.faultAddressReg, multiHitAddr);
		debugOpcodeField = 8'h50;
		pulse(debugOpcodeWr);
		chk(branchValid, 1'h0);
		debugOpcodeField = 8'h7A;
		pulse(debugOpcodeWr);
		entry(12'h000, RV);
		multiHitAddr = 32'h5A5A_7C00;
		pulse(utlbMultiHit);
		entry(12'h140, RV);
		chk(archState.pageTableEntryHigh[31:10], multiHitAddr[31:10]);
		pulse(powerOnReq);
		entry(12'h000, RV);
		chk(powerInit, 1'h1);
		// Nonmaskable request under hold-off: held, then taken once allowed
		pulse(nmiReq);
		tick;
		chk(branchValid, 1'h0);
		nmiAcceptBlocked = 1'h1;
		tick;
		chk(archState.interruptEventCode, 12'h1C0);
		chk(branchTarget, exc_pkg::OFF_INTR);
		chk(archState.savedStatus, exc_pkg::STATUS_RESET);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (2000) @(posedge clock);
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clock);
		#1 nrst = 1'h1;
		tick;
		chk(powerInit, 1'h1);
		chk(branchTarget, RV);
		vectorBaseWrData = VB;
		pulse(vectorBaseWr);
		pulse(statusWr);
		chk(archState.statusWord, '0);
		t_miss;
		t_codes;
		t_block;
		t_resets;
		report_and_stop;
	end
endmodule
